/* test/key_request_checker_monitor.sv */
`timescale 1ns/1ps
`include "key_request_checker_consts.vh"

////////////////////////////////////////////////////////////////////////////
// port-level checker: bus handshake, outcome flags and key write timing
module key_request_checker_monitor #(
	parameter AW = 32
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [7:0]    adr_i,
	input  wire logic [3:0]    sel_i,
	input  wire logic [31:0]   dat_i,
	input  wire logic          ack_o,
	input  wire logic          busy_o,
	input  wire logic [31:0]   result_o,
	input  wire logic [5:0]    flags_o,
	input  wire logic          gp_fault_o,
	input  wire logic          pf_fault_o,
	input  wire logic          key_wr_o,
	input  wire logic [AW-1:0] key_addr_o,
	input  wire logic [127:0]  key_data_o,
	input  wire logic [AW-1:0] range_base_i,
	input  wire logic [AW-1:0] range_limit_i
);
	// single domain, so one clock and one reset for every property
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_next: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_start_busy: assert property ((cyc_i && stb_i && we_i && !ack_o &&
		adr_i == `KRC_OFF_CTRL && sel_i[0] && dat_i[0] && !busy_o) |=> busy_o)
		else $error("start did not raise busy");
	a_err_flags: assert property ((result_o != 32'h0) |->
		flags_o == 6'h20)
		else $error("error result without zero flag alone");
	a_ok_flags: assert property (key_wr_o |-> ##[0:1]
		(flags_o == 6'h00 && result_o == `KRC_RES_OK))
		else $error("key written without clean flags");
	a_key_place: assert property (key_wr_o |-> (key_addr_o[3:0] == 4'h0 &&
		key_addr_o >= range_base_i && key_addr_o <= range_limit_i))
		else $error("key written to bad address");
	a_key_hold: assert property ($changed(key_data_o) |-> key_wr_o)
		else $error("key data moved without a key write");
	a_key_late: assert property (key_wr_o |-> $past(busy_o, 2))
		else $error("key written without derivation");
	a_fault_pulse: assert property ((gp_fault_o || pf_fault_o) |=>
		!(gp_fault_o || pf_fault_o))
		else $error("fault longer than one cycle");
	a_fault_ends: assert property ((gp_fault_o || pf_fault_o) |->
		!key_wr_o ##[0:2] !busy_o)
		else $error("request ran on after a fault");
	a_code_legal: assert property (result_o inside {`KRC_RES_OK,
		`KRC_RES_UNAUTH, `KRC_RES_BAD_CPU, `KRC_RES_VER_HIGH,
		`KRC_RES_UNKNOWN})
		else $error("result code out of set");

	// main scenarios reached
	c_key: cover property (key_wr_o);
	c_gp: cover property (gp_fault_o);
	c_pf: cover property (pf_fault_o);
	c_high: cover property (result_o == `KRC_RES_VER_HIGH);
endmodule

bind key_request_checker key_request_checker_monitor #(.AW(AW))
	key_request_checker_monitor_inst (.*);

/* test/page_map_model.sv */
`timescale 1ns/1ps
`include "key_request_checker_consts.vh"

////////////////////////////////////////////////////////////////////////////
// page map as the enclave sees it: entries follow the two pointers, and
// spoil selects one broken attribute per page (0 none)
module page_map_model #(
	parameter AW = 32
) (
	input  wire logic [AW-1:0]   req_ptr_i,
	input  wire logic [AW-1:0]   out_ptr_i,
	input  wire logic [AW-1:0]   active_struct_i,
	output logic      [1:0]      pg_in_cache_o,
	output logic      [1:0]      pg_valid_o,
	output logic      [1:0]      pg_blocked_o,
	output logic      [15:0]     pg_type_o,
	output logic      [2*AW-1:0] pg_owner_o,
	output logic      [1:0]      pg_pending_o,
	output logic      [1:0]      pg_modified_o,
	output logic      [2*AW-1:0] pg_addr_o,
	output logic      [1:0]      pg_readable_o,
	output logic      [1:0]      pg_writable_o
);
	logic [3:0]    spoil [0:1];
	logic [AW-1:0] ptr;

	// 1 uncached, 2 invalid, 3 blocked, 4 type, 5 owner, 6 pending,
	// 7 modified, 8 address, 9 no access
	always_comb
	begin
		for (int p = 0; p < 2; p++)
		begin
			ptr = p ? out_ptr_i : req_ptr_i;
			pg_in_cache_o[p] = spoil[p] != 4'h1;
			pg_valid_o[p] = spoil[p] != 4'h2;
			pg_blocked_o[p] = spoil[p] == 4'h3;
			pg_type_o[p*8+:8] = (spoil[p] == 4'h4) ? 8'h05 : `KRC_PT_REGULAR;
			pg_owner_o[p*AW+:AW] = active_struct_i + (spoil[p] == 4'h5);
			pg_pending_o[p] = spoil[p] == 4'h6;
			pg_modified_o[p] = spoil[p] == 4'h7;
			// address tag off by one page when spoiled
			pg_addr_o[p*AW+:AW] = (ptr & `KRC_PAGE_MASK) +
				((spoil[p] == 4'h8) ? 32'h00001000 : 32'h00000000);
			pg_readable_o[p] = spoil[p] != 4'h9;
			pg_writable_o[p] = spoil[p] != 4'h9;
		end
	end
endmodule

/* test/tb_key_request_checker.sv */
`timescale 1ns/1ps
`include "key_request_checker_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t line %0d", $time, `__LINE__); end end

////////////////////////////////////////////////////////////////////////////
module tb_key_request_checker;
	logic         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0]   adr_i = 0;
	logic [3:0]   sel_i = 0;
	logic [31:0]  dat_i = 0, dat_o, result_o, fault_addr_o, key_addr_o, rd, st;
	logic         ack_o, busy_o, gp_fault_o, pf_fault_o, key_wr_o;
	logic         req_reserved_nonzero_i, cf_capability_i;
	logic [5:0]   flags_o;
	logic [15:0]  key_selector_i, key_policy_bits_i, req_sw_version_i;
	logic [15:0]  req_cfg_version_i, encl_sw_version_i, encl_cfg_version_i;
	logic [15:0]  product_ident_i, pg_type_i;
	logic [127:0] req_cpu_version_i, attribute_select_mask_i, encl_attr_i;
	logic [127:0] product_family_ident_i, extended_product_ident_i;
	logic [127:0] cpu_security_version_i, owner_epoch_value_i, key_data_o;
	logic [127:0] seal_fuse_value_i, derive_secret_i, last_key;
	logic [31:0]  misc_select_mask_i, misc_feature_set_i, req_ptr, out_ptr;
	logic [31:0]  range_base_i, range_limit_i, active_struct_i;
	logic [7:0]   control_flow_attr_mask_i, encl_cf_attr_i;
	logic [255:0] request_nonce_i, enclave_measurement_i, signer_measurement_i;
	logic [511:0] configuration_ident_i;
	logic [2815:0] encl_padding_i;
	logic [1:0]   pg_in_cache_i, pg_valid_i, pg_blocked_i, pg_pending_i;
	logic [1:0]   pg_modified_i, pg_readable_i, pg_writable_i;
	logic [63:0]  pg_owner_i, pg_addr_i;
	int           n_errors = 0, compares = 0, cycles = 0, nkeys = 0;

	always #12.5 clk_i = ~clk_i;

	key_request_checker key_request_checker_inst (.*);

	page_map_model page_map_model_inst (
		.req_ptr_i(req_ptr), .out_ptr_i(out_ptr),
		.active_struct_i(active_struct_i), .pg_in_cache_o(pg_in_cache_i),
		.pg_valid_o(pg_valid_i), .pg_blocked_o(pg_blocked_i),
		.pg_type_o(pg_type_i), .pg_owner_o(pg_owner_i),
		.pg_pending_o(pg_pending_i), .pg_modified_o(pg_modified_i),
		.pg_addr_o(pg_addr_i), .pg_readable_o(pg_readable_i),
		.pg_writable_o(pg_writable_i));

	// key capture and hang guard; every key must land at the output pointer
	always @(posedge clk_i)
	begin
		cycles++;
		if (key_wr_o === 1'b1)
		begin
			last_key <= key_data_o;
			nkeys++;
			`CHK(key_addr_o, out_ptr)
		end
		if (cycles == 20000)
		begin
			n_errors++;
			final_report;
		end
	end

	task final_report;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// classic single cycle; the timeout ends a missing ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
		sel_i <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0; stb_i <= 1'b0;
	endtask

	// one edge first, so pointers just set by the caller have landed
	task run;
		@(posedge clk_i);
		wb(1'b1, `KRC_OFF_REQ_PTR, req_ptr);
		wb(1'b1, `KRC_OFF_OUT_PTR, out_ptr);
		wb(1'b1, `KRC_OFF_CTRL, 32'h00000001);
		do wb(1'b0, `KRC_OFF_STATUS, 32'h0); while (rd[`KRC_ST_BUSY] !== 1'b0);
		st = rd;
	endtask

	// a legal sealing request that succeeds
	task setup;
		key_selector_i <= `KRC_SEL_SEAL; key_policy_bits_i <= 16'h0000;
		req_reserved_nonzero_i <= 1'b0; cf_capability_i <= 1'b1;
		req_sw_version_i <= 16'h0002; encl_sw_version_i <= 16'h0002;
		req_cfg_version_i <= 16'h0001; encl_cfg_version_i <= 16'h0001;
		req_cpu_version_i <= 128'h5; cpu_security_version_i <= 128'h5;
		attribute_select_mask_i <= 128'h0; encl_attr_i <= 128'h183;
		misc_select_mask_i <= 32'h0; misc_feature_set_i <= 32'h5;
		control_flow_attr_mask_i <= 8'hff; encl_cf_attr_i <= 8'h03;
		request_nonce_i <= {8{32'h1234abcd}};
		enclave_measurement_i <= {8{32'h11}};
		signer_measurement_i <= {8{32'h22}};
		product_family_ident_i <= 128'h33; extended_product_ident_i <= 128'h44;
		product_ident_i <= 16'h0055; configuration_ident_i <= {16{32'h66}};
		encl_padding_i <= {88{32'h77}}; owner_epoch_value_i <= 128'h88;
		seal_fuse_value_i <= 128'h99; derive_secret_i <= 128'haa;
		range_base_i <= 32'h00010000; range_limit_i <= 32'h0001ffff;
		active_struct_i <= 32'h00008000;
		req_ptr <= 32'h00010200; out_ptr <= 32'h00011010;
		page_map_model_inst.spoil[0] <= 4'h0;
		page_map_model_inst.spoil[1] <= 4'h0;
	endtask

	task flip(input int b);
		case (b)
			0: enclave_measurement_i <= ~enclave_measurement_i;
			1: signer_measurement_i <= ~signer_measurement_i;
			2: product_ident_i <= ~product_ident_i;
			3: configuration_ident_i <= ~configuration_ident_i;
			4: product_family_ident_i <= ~product_family_ident_i;
			5: extended_product_ident_i <= ~extended_product_ident_i;
			6: encl_attr_i[8] <= ~encl_attr_i[8];
			7: encl_attr_i[0] <= ~encl_attr_i[0];
			8: misc_feature_set_i[0] <= ~misc_feature_set_i[0];
			9: encl_cf_attr_i[0] <= ~encl_cf_attr_i[0];
			10: request_nonce_i[0] <= ~request_nonce_i[0];
			11: seal_fuse_value_i[0] <= ~seal_fuse_value_i[0];
			12: owner_epoch_value_i[0] <= ~owner_epoch_value_i[0];
			default: encl_padding_i[0] <= ~encl_padding_i[0];
		endcase
	endtask

	// key before and after one input flip; eq says the input is left out
	task pair(input int b, input logic eq);
		logic [127:0] k0;
		run;
		k0 = last_key;
		`CHK(flags_o, 6'h00)
		flip(b);
		run;
		flip(b);
		`CHK(k0 === last_key, eq)
	endtask

	task fault(input logic [2:0] exp);
		run;
		`CHK({st[4], st[3] | st[4], st[2]}, exp)
	endtask

	// error codes leave no key and only the zero flag
	task err(input logic [31:0] code);
		int n;
		n = nkeys;
		run;
		wb(1'b0, `KRC_OFF_RESULT, 32'h0);
		`CHK(rd, code)
		`CHK(flags_o, 6'h20)
		`CHK(nkeys, n)
	endtask

	initial
	begin
		setup;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		run;
		`CHK(st[4:0], 5'h02)
		`CHK(flags_o, 6'h00)
		wb(1'b0, `KRC_OFF_KEY0, 32'h0);
		`CHK(rd, last_key[31:0])
		setup; req_ptr <= 32'h00010300; fault(3'b001);
		setup; req_ptr <= 32'h00020000; fault(3'b001);
		setup; out_ptr <= 32'h00011018; fault(3'b001);
		setup; out_ptr <= 32'h0000fff0; fault(3'b001);
		setup; req_reserved_nonzero_i <= 1'b1; fault(3'b001);
		setup; key_policy_bits_i <= 16'h0040; fault(3'b001);
		setup; encl_attr_i[7] <= 1'b0; fault(3'b001);
		setup; encl_attr_i[7] <= 1'b0; req_cfg_version_i <= 16'h0;
		key_policy_bits_i <= 16'h0004; fault(3'b001);
		for (int p = 0; p < 2; p++)
			for (int k = 1; k < 10; k++)
			begin
				setup;
				page_map_model_inst.spoil[p] <= k[3:0];
				fault({p[0], 2'b10});
				wb(1'b0, `KRC_OFF_FAULT_AD, 32'h0);
				`CHK(rd, p ? out_ptr : req_ptr)
			end
		setup; req_cpu_version_i <= 128'h6; err(`KRC_RES_BAD_CPU);
		setup; req_sw_version_i <= 16'h3; err(`KRC_RES_VER_HIGH);
		setup; req_cfg_version_i <= 16'h2; err(`KRC_RES_VER_HIGH);
		setup; key_selector_i <= 16'h0009; err(`KRC_RES_UNKNOWN);
		setup; key_selector_i <= `KRC_SEL_PROV; err(`KRC_RES_UNAUTH);
		setup; key_selector_i <= `KRC_SEL_LAUNCH; err(`KRC_RES_UNAUTH);
		for (int b = 0; b < 6; b++)
		begin
			setup;
			pair(b, b != 2);
			key_policy_bits_i <= 16'h0001 << b;
			pair(b, b == 2);
		end
		setup;
		pair(6, 1'b1);
		pair(7, 1'b0);
		pair(8, 1'b1);
		pair(9, 1'b0);
		cf_capability_i <= 1'b0;
		pair(9, 1'b1);
		for (int b = 10; b < 14; b++)
			pair(b, 1'b0);
		final_report;
	end
endmodule

/* verilog/key_request_checker.v */
`timescale 1ns/1ps
`include "key_request_checker_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// keyed folding mixer: absorbs the dependency record 128 bits per cycle
module key_mixer #(
	parameter REC_W = 256
) (
	input  wire               clk_i,
	input  wire               rst_i,
	input  wire               start_i,
	input  wire [REC_W-1:0]   record_i,
	input  wire [127:0]       secret_i,
	output reg                done_o,
	output reg  [127:0]       key_o
);
	localparam NCH = REC_W / 128 + 1;
	localparam CW  = $clog2(NCH + 1);

	wire [REC_W+127:0] ext;
	wire [127:0]       chunk;
	reg  [127:0]       acc_r;
	reg  [CW-1:0]      cnt_r;
	reg                run_r;

	// zero tail so the last slice never runs off the record
	assign ext   = {128'h0, record_i};
	assign chunk = ext[cnt_r*128 +: 128];

	// one slice per cycle, secret folded in at the end
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			acc_r  <= 128'h0;
			cnt_r  <= {CW{1'b0}};
			run_r  <= 1'b0;
			done_o <= 1'b0;
			key_o  <= 128'h0;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i && !run_r)
			begin
				acc_r <= secret_i;
				cnt_r <= {CW{1'b0}};
				run_r <= 1'b1;
			end
			else if (run_r)
			begin
				acc_r <= {acc_r[120:0], acc_r[127:121]} ^ chunk;
				if (cnt_r == NCH[CW-1:0] - 1'b1)
				begin
					run_r  <= 1'b0;
					done_o <= 1'b1;
					key_o  <= {acc_r[120:0], acc_r[127:121]} ^ chunk
						^ secret_i;
				end
				else
					cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - unauthorized-key code when enclave lacks the attribute for the key
// - unknown-key code when selector value is not supported
// - version-too-high code when software or config version exceeds enclave
// - protection fault when request pointer misaligned to 512 or out of range
// - protection fault when output pointer misaligned to 16 or out of range
// - page fault on request page not cached, invalid or blocked
// - request page must be regular, owned, settled, readable, address matching
// - same page checks on output page, which must be writable
// - protection fault when reserved request or policy bits are nonzero
// - without key separation, policy mask 0x003c or config version faults
// - sealed attributes are (mask or three) and enclave attributes
// - misc set is misc mask and enclave misc features
// - control-flow mask anded with enclave attributes when capability set
// - processor version too high gives bad-processor code and zero flag
// - software version too high gives version-too-high code, no key
// - config version too high gives the same version-too-high code
// - measurement included only when policy bit set, else zero
// - signer included only when policy bit set, else zero
// - family and extended product included only per policy bits
// - product ident included unless omit bit set
// - config ident and requested config version only when policy bit set
// - record holds versions, epoch, attributes, mask, nonce, fuses, padding
// - error sets zero flag, result code, output buffer untouched
// - success clears all six flags and writes key to output buffer
module key_request_checker #(
	parameter AW    = 32,
	parameter PAD_W = 2816
) (
	input  wire               clk_i,
	input  wire               rst_i,
	// wishbone slave
	input  wire               cyc_i,
	input  wire               stb_i,
	input  wire               we_i,
	input  wire [7:0]         adr_i,
	input  wire [3:0]         sel_i,
	input  wire [31:0]        dat_i,
	output reg  [31:0]        dat_o,
	output reg                ack_o,
	// request block contents
	input  wire [15:0]        key_selector_i,
	input  wire [15:0]        key_policy_bits_i,
	input  wire               req_reserved_nonzero_i,
	input  wire [15:0]        req_sw_version_i,
	input  wire [15:0]        req_cfg_version_i,
	input  wire [127:0]       req_cpu_version_i,
	input  wire [127:0]       attribute_select_mask_i,
	input  wire [31:0]        misc_select_mask_i,
	input  wire [7:0]         control_flow_attr_mask_i,
	input  wire [255:0]       request_nonce_i,
	// enclave control struct contents
	input  wire [127:0]       encl_attr_i,
	input  wire [31:0]        misc_feature_set_i,
	input  wire [7:0]         encl_cf_attr_i,
	input  wire [15:0]        encl_sw_version_i,
	input  wire [15:0]        encl_cfg_version_i,
	input  wire [255:0]       enclave_measurement_i,
	input  wire [255:0]       signer_measurement_i,
	input  wire [127:0]       product_family_ident_i,
	input  wire [127:0]       extended_product_ident_i,
	input  wire [15:0]        product_ident_i,
	input  wire [511:0]       configuration_ident_i,
	input  wire [PAD_W-1:0]   encl_padding_i,
	// platform state
	input  wire [127:0]       cpu_security_version_i,
	input  wire [127:0]       owner_epoch_value_i,
	input  wire [127:0]       seal_fuse_value_i,
	input  wire [127:0]       derive_secret_i,
	input  wire               cf_capability_i,
	input  wire [AW-1:0]      range_base_i,
	input  wire [AW-1:0]      range_limit_i,
	input  wire [AW-1:0]      active_struct_i,
	// page map entries: index 0 request page, 1 output page
	input  wire [1:0]         pg_in_cache_i,
	input  wire [1:0]         pg_valid_i,
	input  wire [1:0]         pg_blocked_i,
	input  wire [15:0]        pg_type_i,
	input  wire [2*AW-1:0]    pg_owner_i,
	input  wire [1:0]         pg_pending_i,
	input  wire [1:0]         pg_modified_i,
	input  wire [2*AW-1:0]    pg_addr_i,
	input  wire [1:0]         pg_readable_i,
	input  wire [1:0]         pg_writable_i,
	// outcome
	output wire               busy_o,
	output reg  [31:0]        result_o,
	output reg  [5:0]         flags_o,
	output reg                gp_fault_o,
	output reg                pf_fault_o,
	output reg  [AW-1:0]      fault_addr_o,
	output reg                key_wr_o,
	output reg  [AW-1:0]      key_addr_o,
	output reg  [127:0]       key_data_o
);
	localparam REC_W = 16 + 128 + 128 + 16 + 16 + 128 + 128 + 128 + 256
		+ 256 + 256 + 128 + 128 + PAD_W + 32 + 32 + 16 + 512 + 16 + 8 + 8;
	localparam ST_IDLE   = 2'd0;
	localparam ST_CHECK  = 2'd1;
	localparam ST_DERIVE = 2'd2;

	reg  [1:0]    state_r;
	reg  [31:0]   req_ptr_r;
	reg  [31:0]   out_ptr_r;
	reg           done_r;
	reg           gp_r;
	reg           pf_r;
	reg           pf_out_r;
	reg           mix_go_r;
	wire          mix_done;
	wire [127:0]  mix_key;
	wire          wb_req;
	wire          wb_wr;
	wire [AW-1:0] ptr [0:1];
	wire [1:0]    page_bad;
	wire [1:0]    page_perm;

	assign busy_o = (state_r != ST_IDLE);
	assign wb_req = cyc_i && stb_i && !ack_o;
	assign wb_wr  = wb_req && we_i;
	assign ptr[0] = req_ptr_r[AW-1:0];
	assign ptr[1] = out_ptr_r[AW-1:0];
	assign page_perm = {pg_writable_i[1], pg_readable_i[0]};

	////////////////////////////////////////////////////////////////////////
	// page map checks, identical for both pages except the permission
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : page_chk
			assign page_bad[g] = !pg_in_cache_i[g] || !pg_valid_i[g]
				|| pg_blocked_i[g]
				|| pg_type_i[g*8 +: 8] != `KRC_PT_REGULAR
				|| pg_owner_i[g*AW +: AW] != active_struct_i
				|| pg_pending_i[g] || pg_modified_i[g]
				|| pg_addr_i[g*AW +: AW]
					!= (ptr[g] & `KRC_PAGE_MASK)
				|| !page_perm[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// operand and policy checks
	wire req_gp = ((ptr[0] & `KRC_REQ_ALIGN_M) != 0)
		|| ptr[0] < range_base_i || ptr[0] > range_limit_i;
	wire out_gp = ((ptr[1] & `KRC_OUT_ALIGN_M) != 0)
		|| ptr[1] < range_base_i || ptr[1] > range_limit_i;
	wire rsv_gp = req_reserved_nonzero_i
		|| (key_policy_bits_i & `KRC_POL_RSV_MASK) != 0;
	wire sep_gp = !encl_attr_i[`KRC_ATTR_KSS]
		&& ((key_policy_bits_i & `KRC_POL_SEP_MASK) != 0
		|| req_cfg_version_i != 0);

	wire is_seal = key_selector_i == `KRC_SEL_SEAL;
	wire is_prov = key_selector_i == `KRC_SEL_PROV
		|| key_selector_i == `KRC_SEL_PROV_SEAL;
	wire is_launch = key_selector_i == `KRC_SEL_LAUNCH;
	// gated keys without their attribute are refused
	wire unauth = (is_prov && !encl_attr_i[`KRC_ATTR_PROV])
		|| (is_launch && !encl_attr_i[`KRC_ATTR_LAUNCH]);
	// only the sealing key is derived here; others read as unsupported unless already refused as unauthorized
	wire unknown = !is_seal;
	wire cpu_high = req_cpu_version_i > cpu_security_version_i;
	wire sw_high  = req_sw_version_i > encl_sw_version_i;
	wire cfg_high = req_cfg_version_i > encl_cfg_version_i;

	////////////////////////////////////////////////////////////////////////
	// derived fields and dependency record
	wire [127:0] seal_attr = (attribute_select_mask_i | `KRC_SEAL_REQ_MASK)
		& encl_attr_i;
	wire [31:0]  misc_set = misc_select_mask_i
		& misc_feature_set_i;
	wire [7:0]   cf_attr = cf_capability_i ?
		(control_flow_attr_mask_i & encl_cf_attr_i) : 8'h00;
	wire [7:0]   cf_mask = cf_capability_i ?
		control_flow_attr_mask_i : 8'h00;
	wire [255:0] t_meas = key_policy_bits_i[`KRC_POL_MEASURE] ?
		enclave_measurement_i : 256'h0;
	wire [255:0] t_sign = key_policy_bits_i[`KRC_POL_SIGNER] ?
		signer_measurement_i : 256'h0;
	wire [127:0] t_fam = key_policy_bits_i[`KRC_POL_FAMILY] ?
		product_family_ident_i : 128'h0;
	wire [127:0] t_ext = key_policy_bits_i[`KRC_POL_EXT_PROD] ?
		extended_product_ident_i : 128'h0;
	wire [15:0]  t_prod = key_policy_bits_i[`KRC_POL_NO_PROD] ?
		16'h0 : product_ident_i;
	wire [511:0] t_cfg = key_policy_bits_i[`KRC_POL_CONFIG] ?
		configuration_ident_i : 512'h0;
	wire [15:0]  t_cfgv = key_policy_bits_i[`KRC_POL_CONFIG] ?
		req_cfg_version_i : 16'h0;

	// field order is fixed; reordering changes every derived key
	wire [REC_W-1:0] record = {
		`KRC_SEL_SEAL, t_fam, t_ext, t_prod, req_sw_version_i,
		owner_epoch_value_i, seal_attr, attribute_select_mask_i,
		t_meas, t_sign, request_nonce_i, seal_fuse_value_i,
		req_cpu_version_i, encl_padding_i, misc_set,
		~misc_select_mask_i, key_policy_bits_i, t_cfg, t_cfgv,
		cf_attr, cf_mask};

	key_mixer #(
		.REC_W (REC_W)
	) u_mixer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.start_i  (mix_go_r),
		.record_i (record),
		.secret_i (derive_secret_i),
		.done_o   (mix_done),
		.key_o    (mix_key)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer: faults in order, then error codes, then derivation
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r      <= ST_IDLE;
			done_r       <= 1'b0;
			gp_r         <= 1'b0;
			pf_r         <= 1'b0;
			pf_out_r     <= 1'b0;
			mix_go_r     <= 1'b0;
			result_o     <= `KRC_RES_OK;
			flags_o      <= 6'h00;
			gp_fault_o   <= 1'b0;
			pf_fault_o   <= 1'b0;
			fault_addr_o <= {AW{1'b0}};
			key_wr_o     <= 1'b0;
			key_addr_o   <= {AW{1'b0}};
			key_data_o   <= 128'h0;
		end
		else
		begin
			gp_fault_o <= 1'b0;
			pf_fault_o <= 1'b0;
			key_wr_o   <= 1'b0;
			mix_go_r   <= 1'b0;
			case (state_r)
			ST_IDLE:
				if (wb_wr && adr_i == `KRC_OFF_CTRL && sel_i[0]
					&& dat_i[`KRC_CTRL_START])
				begin
					state_r  <= ST_CHECK;
					done_r   <= 1'b0;
					gp_r     <= 1'b0;
					pf_r     <= 1'b0;
					pf_out_r <= 1'b0;
				end
			ST_CHECK:
			begin
				state_r <= ST_IDLE;
				done_r  <= 1'b1;
				if (req_gp)
				begin
					gp_r       <= 1'b1;
					gp_fault_o <= 1'b1;
				end
				else if (page_bad[0])
				begin
					pf_r         <= 1'b1;
					pf_fault_o   <= 1'b1;
					fault_addr_o <= ptr[0];
				end
				else if (out_gp)
				begin
					gp_r       <= 1'b1;
					gp_fault_o <= 1'b1;
				end
				else if (page_bad[1])
				begin
					pf_r         <= 1'b1;
					pf_out_r     <= 1'b1;
					pf_fault_o   <= 1'b1;
					fault_addr_o <= ptr[1];
				end
				else if (rsv_gp || sep_gp)
				begin
					gp_r       <= 1'b1;
					gp_fault_o <= 1'b1;
				end
				else if (unauth || unknown || cpu_high || sw_high
					|| cfg_high)
				begin
					flags_o <= 6'h20;
					if (unauth)
						result_o <= `KRC_RES_UNAUTH;
					else if (unknown)
						result_o <= `KRC_RES_UNKNOWN;
					else if (cpu_high)
						result_o <= `KRC_RES_BAD_CPU;
					else
						result_o <= `KRC_RES_VER_HIGH;
				end
				else
				begin
					state_r  <= ST_DERIVE;
					done_r   <= 1'b0;
					mix_go_r <= 1'b1;
				end
			end
			ST_DERIVE:
				if (mix_done)
				begin
					state_r    <= ST_IDLE;
					done_r     <= 1'b1;
					result_o   <= `KRC_RES_OK;
					flags_o    <= 6'h00;
					key_wr_o   <= 1'b1;
					key_addr_o <= ptr[1];
					key_data_o <= mix_key;
				end
			default:
				state_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pointer registers with byte lanes; frozen while a request runs
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1)
		begin : ptr_lane
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					req_ptr_r[b*8 +: 8] <= 8'h00;
					out_ptr_r[b*8 +: 8] <= 8'h00;
				end
				else if (wb_wr && sel_i[b] && state_r == ST_IDLE)
				begin
					if (adr_i == `KRC_OFF_REQ_PTR)
						req_ptr_r[b*8 +: 8] <= dat_i[b*8 +: 8];
					if (adr_i == `KRC_OFF_OUT_PTR)
						out_ptr_r[b*8 +: 8] <= dat_i[b*8 +: 8];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// wishbone answer: one wait state, unmapped reads give zero
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end
		else
		begin
			ack_o <= wb_req;
			dat_o <= 32'h0;
			if (wb_req && !we_i)
				case (adr_i)
				`KRC_OFF_STATUS:
					dat_o <= {27'h0, pf_out_r, pf_r, gp_r, done_r, busy_o};
				`KRC_OFF_REQ_PTR:  dat_o <= req_ptr_r;
				`KRC_OFF_OUT_PTR:  dat_o <= out_ptr_r;
				`KRC_OFF_RESULT:   dat_o <= result_o;
				`KRC_OFF_FAULT_AD: dat_o <= {{(32-AW){1'b0}}, fault_addr_o};
				8'h20:             dat_o <= key_data_o[31:0];
				8'h24:             dat_o <= key_data_o[63:32];
				8'h28:             dat_o <= key_data_o[95:64];
				`KRC_OFF_KEY3:     dat_o <= key_data_o[127:96];
				default:           dat_o <= 32'h0;
				endcase
		end
	end
endmodule

/* verilog/key_request_checker_consts.vh */
`ifndef KEY_REQUEST_CHECKER_CONSTS_VH
`define KEY_REQUEST_CHECKER_CONSTS_VH

// wishbone byte offsets
`define KRC_OFF_CTRL      8'h00
`define KRC_OFF_STATUS    8'h04
`define KRC_OFF_REQ_PTR   8'h08
`define KRC_OFF_OUT_PTR   8'h0c
`define KRC_OFF_RESULT    8'h10
`define KRC_OFF_FAULT_AD  8'h14
`define KRC_OFF_KEY0      8'h20
`define KRC_OFF_KEY3      8'h2c

// control and status bit positions
`define KRC_CTRL_START    0
`define KRC_ST_BUSY       0
`define KRC_ST_DONE       1
`define KRC_ST_GP         2
`define KRC_ST_PF         3
`define KRC_ST_PF_OUT     4

// result codes (values are arbitrary)
`define KRC_RES_OK        32'h00000000
`define KRC_RES_UNAUTH    32'h00000001
`define KRC_RES_BAD_CPU   32'h00000002
`define KRC_RES_VER_HIGH  32'h00000003
`define KRC_RES_UNKNOWN   32'h00000004

// key selector encodings (values are arbitrary)
`define KRC_SEL_LAUNCH    16'h0000
`define KRC_SEL_PROV      16'h0001
`define KRC_SEL_PROV_SEAL 16'h0002
`define KRC_SEL_REPORT    16'h0003
`define KRC_SEL_SEAL      16'h0004

// policy bits
`define KRC_POL_MEASURE   0
`define KRC_POL_SIGNER    1
`define KRC_POL_NO_PROD   2
`define KRC_POL_CONFIG    3
`define KRC_POL_FAMILY    4
`define KRC_POL_EXT_PROD  5
`define KRC_POL_SEP_MASK  16'h003c
`define KRC_POL_RSV_MASK  16'hffc0

// enclave attribute bits
`define KRC_ATTR_PROV     4
`define KRC_ATTR_LAUNCH   5
`define KRC_ATTR_KSS      7
`define KRC_SEAL_REQ_MASK 128'h00000000000000000000000000000003

// alignment and page geometry
`define KRC_REQ_ALIGN_M   32'h000001ff
`define KRC_OUT_ALIGN_M   32'h0000000f
`define KRC_PAGE_MASK     32'hfffff000
`define KRC_PT_REGULAR    8'h00

`endif
